// ==== rtl/mbg_bus_if.sv ====
// interface joining the microcontroller core to the bus glue
`timescale 1ns/1ps
interface mbg_bus_if;
    logic [7:0] ad_out;
    logic       ad_oe;
    logic [7:0] ad_in;
    logic [7:0] high_addr_port;
    logic       ale;
    logic       program_fetch_strobe_n;
    logic       rd_n;
    logic       wr_n;
    logic       watchdog_kick;
    logic       cpu_reset;
    logic       external_access_sel;
    modport core (output ad_out, ad_oe, high_addr_port, ale, program_fetch_strobe_n,
                  rd_n, wr_n, watchdog_kick,
                  input ad_in, cpu_reset, external_access_sel);
    modport glue (input ad_out, ad_oe, high_addr_port, ale, program_fetch_strobe_n,
                  rd_n, wr_n, watchdog_kick,
                  output ad_in, cpu_reset, external_access_sel);
endinterface

// ==== rtl/mbg_core_end.sv ====
// core end: drives bus cycles requested on a user port and kicks the watchdog
`timescale 1ns/1ps
module mbg_core_end #(
    parameter int PHASE_CYC = 4
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    // user request
    input  wire logic        req_in,
    input  wire logic [1:0]  kind_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        kick_in,
    output logic             busy_out,
    output logic             done_out,
    output logic [7:0]       rdata_out,
    output logic             in_reset_out,
    // glue side
    mbg_bus_if.core          bus
);
    initial begin
        if (PHASE_CYC < 3) $error("PHASE_CYC too small");
    end
    // kind: 0 fetch, 1 data read, 2 write
    logic [2:0]  st_q, st_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [1:0]  k_q, k_d;
    logic [15:0] a_q, a_d;
    logic [7:0]  w_q, w_d, r_q, r_d;
    logic        done_q, done_d, kick_q, kick_d;
    logic        r1_q, r2_q;
    localparam logic [7:0] LAST = 8'(PHASE_CYC - 1);
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; k_d = k_q; a_d = a_q; w_d = w_q; r_d = r_q;
        done_d = 1'b0;
        kick_d = kick_in;
        if (st_q == 3'd0) begin
            if (req_in && !r2_q) begin
                st_d = 3'd1; cnt_d = 8'h00; k_d = kind_in; a_d = addr_in; w_d = wdata_in;
            end
        end else if (cnt_q == LAST) begin
            cnt_d = 8'h00;
            if (st_q == 3'd2 && k_q != 2'd2) r_d = bus.ad_in;
            st_d = (st_q == 3'd2) ? 3'd0 : st_q + 3'd1;
            done_d = (st_q == 3'd2);
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= 3'd0; cnt_q <= 8'h00; k_q <= 2'd0; a_q <= 16'h0000;
            w_q <= 8'h00; r_q <= 8'h00; done_q <= 1'b0; kick_q <= 1'b0;
            r1_q <= 1'b1; r2_q <= 1'b1;
        end else if (clk_en_in) begin
            st_q <= st_d; cnt_q <= cnt_d; k_q <= k_d; a_q <= a_d;
            w_q <= w_d; r_q <= r_d; done_q <= done_d; kick_q <= kick_d;
            r1_q <= bus.cpu_reset; r2_q <= r1_q;
        end
    end
    wire act = (st_q == 3'd2);
    assign bus.ale            = (st_q == 3'd1);
    assign bus.high_addr_port = a_q[15:8];
    assign bus.ad_out         = (st_q == 3'd1) ? a_q[7:0] : w_q;
    assign bus.ad_oe          = (st_q == 3'd1) || (act && k_q == 2'd2);
    assign bus.program_fetch_strobe_n = !(act && k_q == 2'd0);
    assign bus.rd_n           = !(act && k_q == 2'd1);
    assign bus.wr_n           = !(act && k_q == 2'd2);
    assign bus.watchdog_kick  = kick_q;
    assign busy_out     = (st_q != 3'd0);
    assign done_out     = done_q;
    assign rdata_out    = r_q;
    assign in_reset_out = r2_q;
endmodule // mbg_core_end

// ==== rtl/mbg_glue.sv ====
// bus glue end: address latch, RAM, decoder, latches, transceiver, watchdog
`timescale 1ns/1ps
module mbg_glue #(
    parameter int HALF_CYC = mbg_pkg::WD_HALF_CYC
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       clk_en_in,
    // core side
    mbg_bus_if.glue         bus,
    // board controls
    input  wire logic       manual_reset_button_in,
    input  wire logic       watchdog_disable_jumper_in,
    // peripheral bus
    input  wire logic [7:0] periph_data_in,
    output logic [7:0]      periph_data_out,
    output logic            periph_oe_out,
    output logic            xcvr_en_out,
    output logic            xcvr_to_core_out,
    // program memory
    output logic [15:0]     addr_out,
    output logic            prog_en_out,
    input  wire logic [7:0] prog_data_in,
    // latches, read select and core reset
    output logic [31:0]     latch_out,
    output logic            rd_sel_out,
    output logic            cpu_reset_out
);
    initial begin
        if (HALF_CYC < 2) $error("HALF_CYC too small");
    end
    // pin synchronisers, two stages each
    logic [15:0] s1_q, s2_q;
    logic [7:0]  ad1_q, ad2_q;
    logic [7:0]  ha1_q, ha2_q;
    logic        oe1_q, oe2_q;
    logic        kick_old_q;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // idle pin levels, so release brings no false strobe or manual reset
            s1_q <= 16'h0007; s2_q <= 16'h0007;
            ad1_q <= 8'h00; ad2_q <= 8'h00;
            ha1_q <= 8'h00; ha2_q <= 8'h00;
            oe1_q <= 1'b0; oe2_q <= 1'b0;
            kick_old_q <= 1'b0;
        end else if (clk_en_in) begin
            s1_q <= {9'h000, bus.ale, watchdog_disable_jumper_in, manual_reset_button_in,
                     bus.watchdog_kick, bus.wr_n, bus.rd_n, bus.program_fetch_strobe_n};
            s2_q <= s1_q;
            ad1_q <= bus.ad_out; ad2_q <= ad1_q;
            ha1_q <= bus.high_addr_port; ha2_q <= ha1_q;
            oe1_q <= bus.ad_oe; oe2_q <= oe1_q;
            kick_old_q <= s2_q[3];
        end
    end
    wire program_fetch_strobe_n_n = s2_q[0];
    wire rd_n   = s2_q[1];
    wire wr_n   = s2_q[2];
    wire kick   = s2_q[3];
    wire man    = s2_q[4];
    wire wd_dis = s2_q[5];
    wire ale    = s2_q[6];

    function automatic logic is_io(input logic [15:0] a);
        return (a & mbg_pkg::IO_MASK) == mbg_pkg::IO_BASE;
    endfunction

    // address latch and bus phase
    mbg_pkg::mbg_phase_t ph_q, ph_d;
    logic [7:0]  lo_q, lo_d;
    logic [7:0]  ram [mbg_pkg::RAM_DEPTH];
    logic [7:0]  rdat_q, rdat_d;
    logic        drive_q, drive_d;
    logic [31:0] lat_q, lat_d;
    logic        wsel_q, wsel_d;
    logic [1:0]  widx_q, widx_d;
    logic [7:0]  wdat_q, wdat_d;
    logic        ramwr;
    logic [15:0] a;
    logic        dec_en, ram_en, xen;
    always_comb begin
        ph_d = ph_q; lo_d = lo_q;
        if (ale) begin
            ph_d = mbg_pkg::MBG_ADDR;
            lo_d = ad2_q;
        end else if (!rd_n || !wr_n || !program_fetch_strobe_n_n) begin
            ph_d = mbg_pkg::MBG_DATA;
        end else if (ph_q == mbg_pkg::MBG_DATA) begin
            ph_d = mbg_pkg::MBG_IDLE;
        end
        a      = {ha2_q, lo_q};
        ram_en = (a <= mbg_pkg::RAM_TOP) && !a[mbg_pkg::RAM_DIS_BIT];
        dec_en = a[mbg_pkg::PERIPH_BIT] && a[mbg_pkg::DEC_EN_BIT];
        xen    = a[mbg_pkg::PERIPH_BIT] && (!rd_n || !wr_n);
        ramwr  = ram_en && !wr_n && oe2_q;
        wdat_d = ad2_q;
        widx_d = a[1:0];
        wsel_d = dec_en && is_io(a) && !wr_n;
        lat_d  = lat_q;
        if (wsel_q && !wsel_d) begin
            lat_d[widx_q*8 +: 8] = wdat_q;
        end
        // prog space never answers a data read, RAM never a fetch
        drive_d = 1'b0;
        rdat_d  = rdat_q;
        if (!program_fetch_strobe_n_n) begin
            drive_d = 1'b1;
            rdat_d  = prog_data_in;
        end else if (!rd_n && ram_en) begin
            drive_d = 1'b1;
            rdat_d  = ram[a[10:0]];
        end else if (!rd_n && xen) begin
            drive_d = 1'b1;
            rdat_d  = periph_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ph_q <= mbg_pkg::MBG_IDLE; lo_q <= 8'h00; rdat_q <= 8'h00;
            drive_q <= 1'b0; lat_q <= {mbg_pkg::NUM_LATCH{mbg_pkg::LATCH_RST}};
            wsel_q <= 1'b0; widx_q <= 2'h0; wdat_q <= 8'h00;
        end else if (clk_en_in) begin
            ph_q <= ph_d; lo_q <= lo_d; rdat_q <= rdat_d; drive_q <= drive_d;
            lat_q <= lat_d; wsel_q <= wsel_d; widx_q <= widx_d; wdat_q <= wdat_d;
        end
    end
    always_ff @(posedge clk_in) begin
        if (clk_en_in && ramwr) ram[a[10:0]] <= ad2_q;
    end

    // outputs, registered
    logic [15:0] addr_q;
    logic        pen_q, xen_q, xdir_q, rsel_q, poe_q;
    logic [7:0]  pdo_q;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            addr_q <= 16'h0000; pen_q <= 1'b0; xen_q <= 1'b0; xdir_q <= 1'b0;
            rsel_q <= 1'b0; poe_q <= 1'b0; pdo_q <= 8'h00;
        end else if (clk_en_in) begin
            addr_q <= a;
            pen_q  <= !program_fetch_strobe_n_n;
            xen_q  <= xen;
            xdir_q <= !rd_n;
            rsel_q <= dec_en && is_io(a) && (a[1:0] == 2'h0) && !rd_n;
            poe_q  <= xen && rd_n;
            pdo_q  <= ad2_q;
        end
    end

    logic wd_rst;
    mbg_watchdog #(.HALF_CYC(HALF_CYC)) u_wd (
        .clk_in       (clk_in),
        .arst_n_in    (arst_n_in),
        .clk_en_in    (clk_en_in),
        .kick_rise_in (kick && !kick_old_q),
        .manual_in    (man),
        .disable_in   (wd_dis),
        .rst_out      (wd_rst)
    );

    assign bus.ad_in  = drive_q ? rdat_q : 8'h00;
    assign bus.cpu_reset = wd_rst;
    assign bus.external_access_sel = 1'b0;
    assign addr_out         = addr_q;
    assign prog_en_out      = pen_q;
    assign xcvr_en_out      = xen_q;
    assign xcvr_to_core_out = xdir_q;
    assign periph_oe_out    = poe_q;
    assign periph_data_out  = pdo_q;
    assign latch_out        = lat_q;
    assign rd_sel_out       = rsel_q;
    assign cpu_reset_out    = wd_rst;
endmodule // mbg_glue

// ==== rtl/mbg_pkg.sv ====
// shared constants for the microcontroller bus glue and watchdog
package mbg_pkg;
    localparam int          CLK_HZ        = 125_000_000;
    localparam int          CRYSTAL_HZ    = 11_520_000;
    localparam int          WD_PERIOD_MS  = 1500;
    localparam longint      WD_PERIOD_CYC = longint'(CLK_HZ) * WD_PERIOD_MS / 1000;
    localparam int          WD_HALF_CYC   = int'(WD_PERIOD_CYC / 2);
    localparam logic [15:0] RAM_TOP       = 16'h07FF;
    localparam int          RAM_DEPTH     = 2048;
    localparam int          PERIPH_BIT    = 15;
    localparam int          DEC_EN_BIT    = 13;
    localparam int          RAM_DIS_BIT   = 11;
    localparam logic [15:0] IO_BASE       = 16'hA800;
    localparam logic [15:0] IO_MASK       = 16'hFFFC;
    localparam logic [7:0]  LATCH_RST     = 8'h00;
    localparam int          NUM_LATCH     = 4;
    typedef enum logic [1:0] {
        MBG_IDLE = 2'b00,
        MBG_ADDR = 2'b01,
        MBG_DATA = 2'b11
    } mbg_phase_t;
    typedef enum logic [1:0] {
        MBG_WD_RUN  = 2'b00,
        MBG_WD_RST  = 2'b01,
        MBG_WD_HOLD = 2'b11
    } mbg_wd_t;
endpackage

// ==== rtl/mbg_watchdog.sv ====
// retriggerable watchdog with manual reset and disable
`timescale 1ns/1ps
module mbg_watchdog #(
    parameter int HALF_CYC = mbg_pkg::WD_HALF_CYC
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic clk_en_in,
    // controls, already synchronised
    input  wire logic kick_rise_in,
    input  wire logic manual_in,
    input  wire logic disable_in,
    // reset to the core
    output logic      rst_out
);
    initial begin
        if (HALF_CYC < 2) $error("HALF_CYC too small");
    end
    mbg_pkg::mbg_wd_t st_q;
    mbg_pkg::mbg_wd_t st_d;
    logic [31:0]      cnt_q;
    logic [31:0]      cnt_d;
    logic             rst_q;
    logic             rst_d;
    localparam logic [31:0] LAST = 32'(HALF_CYC - 1);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        rst_d = rst_q;
        if (manual_in) begin
            st_d  = mbg_pkg::MBG_WD_HOLD;
            cnt_d = '0;
        end else begin
            unique case (st_q)
                mbg_pkg::MBG_WD_RUN: begin
                    if (kick_rise_in || disable_in) begin
                        cnt_d = '0;
                    end else if (cnt_q == LAST) begin
                        cnt_d = '0;
                        st_d  = mbg_pkg::MBG_WD_RST;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
                mbg_pkg::MBG_WD_RST: begin
                    if (cnt_q == LAST) begin
                        cnt_d = '0;
                        st_d  = mbg_pkg::MBG_WD_RUN;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
                mbg_pkg::MBG_WD_HOLD: begin
                    cnt_d = '0;
                    st_d  = mbg_pkg::MBG_WD_RST;
                end
                // unused code: recover through a reset pulse
                default: begin
                    cnt_d = '0;
                    st_d  = mbg_pkg::MBG_WD_RST;
                end
            endcase
        end
        rst_d = (st_d != mbg_pkg::MBG_WD_RUN);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q  <= mbg_pkg::MBG_WD_RUN;
            cnt_q <= '0;
            rst_q <= 1'b0;
        end else if (clk_en_in) begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            rst_q <= rst_d;
        end
    end
    assign rst_out = rst_q;
endmodule // mbg_watchdog

// ==== test/mbg_properties.sv ====
// concurrent checks on the bus between the core end and the glue
`timescale 1ns/1ps
module mbg_properties (
    // clock and reset
    input wire logic       clk_in,
    input wire logic       arst_n_in,
    // bus signals
    input wire logic [7:0] ad_out,
    input wire logic       ad_oe,
    input wire logic [7:0] ad_in,
    input wire logic       ale,
    input wire logic       program_fetch_strobe_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       external_access_sel
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_ea_low; external_access_sel == 1'b0; endproperty
    a_ea_low: assert property (p_ea_low) else $error("access select not low");
    property p_one_strobe; $onehot0({~rd_n, ~wr_n, ~program_fetch_strobe_n}); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("two strobes at once");
    property p_ale_quiet; ale |-> rd_n && wr_n && program_fetch_strobe_n; endproperty
    a_ale_quiet: assert property (p_ale_quiet) else $error("strobe during ale");
    property p_ale_len; $rose(ale) |-> ale[*4] ##1 !ale; endproperty
    a_ale_len: assert property (p_ale_len) else $error("ale length");
    property p_addr_hold; ale && $past(ale) |-> ad_oe && $stable(ad_out); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_wr_len; $fell(wr_n) |-> (!wr_n)[*4] ##1 wr_n; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe length");
    property p_wr_data; !wr_n && !$past(wr_n) |-> ad_oe && $stable(ad_out); endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data moved");
    // core must let go of the port while anyone may answer
    property p_rd_free; !(rd_n && program_fetch_strobe_n) |-> !ad_oe; endproperty
    a_rd_free: assert property (p_rd_free) else $error("core drives in read");
    property p_ad_quiet; (rd_n && program_fetch_strobe_n)[*5] |-> ad_in == 8'h00; endproperty
    a_ad_quiet: assert property (p_ad_quiet) else $error("glue drives idle");
endmodule // mbg_properties

// ==== test/testbench.sv ====
// self-checking bench joining the core end and the bus glue
`timescale 1ns/1ps
module testbench;
    localparam int HALF = 50;
    logic        clk_in;
    logic        arst_n_in;
    logic        req;
    logic [1:0]  kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        kick;
    logic        kick_on;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    logic        in_rst;
    logic        manual;
    logic        jumper;
    logic [7:0]  periph_in;
    logic        xcvr_en;
    logic        to_core;
    logic [15:0] addr_out;
    logic        prog_en;
    logic [7:0]  prog_in;
    logic [31:0] latch;
    logic        rd_sel;
    logic        cpu_rst;
    logic [7:0]  pdo;
    logic        poe;
    logic [5:0]  seen;
    int          n_errors;
    int          checks_done;

    mbg_bus_if u_mbg_bus_if ();
    mbg_glue #(.HALF_CYC(HALF)) u_mbg_glue (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1), .bus(u_mbg_bus_if),
        .manual_reset_button_in(manual), .watchdog_disable_jumper_in(jumper),
        .periph_data_in(periph_in), .periph_data_out(pdo), .periph_oe_out(poe),
        .xcvr_en_out(xcvr_en), .xcvr_to_core_out(to_core), .addr_out(addr_out),
        .prog_en_out(prog_en), .prog_data_in(prog_in), .latch_out(latch),
        .rd_sel_out(rd_sel), .cpu_reset_out(cpu_rst));
    mbg_core_end #(.PHASE_CYC(4)) u_mbg_core_end (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1), .req_in(req),
        .kind_in(kind), .addr_in(addr), .wdata_in(wdata), .kick_in(kick), .busy_out(busy),
        .done_out(done), .rdata_out(rdata), .in_reset_out(in_rst), .bus(u_mbg_bus_if));
    mbg_properties u_mbg_properties (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .ad_out(u_mbg_bus_if.ad_out),
        .ad_oe(u_mbg_bus_if.ad_oe), .ad_in(u_mbg_bus_if.ad_in), .ale(u_mbg_bus_if.ale),
        .program_fetch_strobe_n(u_mbg_bus_if.program_fetch_strobe_n),
        .rd_n(u_mbg_bus_if.rd_n), .wr_n(u_mbg_bus_if.wr_n),
        .external_access_sel(u_mbg_bus_if.external_access_sel));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // kicks every 20 cycles, well inside the watchdog half period
    initial begin
        kick = 1'b0;
        forever begin
            repeat (10) @(negedge clk_in);
            kick = kick_on ? ~kick : 1'b0;
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic watch(input logic [15:0] a);
        seen = seen | {poe === 1'b1, addr_out === a, rd_sel === 1'b1, to_core === 1'b1,
                       xcvr_en === 1'b1, prog_en === 1'b1};
    endtask

    // one bus cycle through the core end; side outputs judged for every kind
    task automatic bus_op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while ((busy !== 1'b0 || in_rst !== 1'b0) && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        req = 1'b1;
        kind = k;
        addr = a;
        wdata = d;
        seen = 6'h00;
        @(negedge clk_in);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            watch(a);
            @(negedge clk_in);
            n++;
        end
        check(done === 1'b1, "no done");
        // glue sees strobes through a sync, so its outputs trail done
        repeat (5) begin
            watch(a);
            @(negedge clk_in);
        end
        check(seen[0] === (k == 2'h0), "fetch enable");
        check(seen[1] === (k != 2'h0 && a[15]), "xcvr enable");
        check(seen[2] === (k == 2'h1), "xcvr direction");
        check(seen[3] === (k == 2'h1 && a == 16'hA800), "read select");
        check(seen[4] === 1'b1, "latched address");
        check(seen[5] === (k == 2'h2 && a[15]), "periph drive");
        if (k == 2'h2 && a[15]) begin
            check(pdo === d, "periph data");
        end
    endtask

    task automatic t_latches();
        logic [15:0] bad [4] = '{16'h2800, 16'h8800, 16'hA804, 16'h0800};
        for (int i = 0; i < 4; i++) begin
            bus_op(2'h2, 16'hA800 + 16'(i), 8'(8'h11 * (i + 1)));
        end
        check(latch === 32'h4433_2211, "latch data");
        for (int i = 0; i < 4; i++) begin
            bus_op(2'h2, bad[i], 8'hFF);
        end
        check(latch === 32'h4433_2211, "stray select");
        $display("test latches done");
    endtask

    task automatic t_reads();
        periph_in = 8'h5A;
        bus_op(2'h1, 16'hA800, 8'h00);
        check(rdata === 8'h5A, "periph read");
        bus_op(2'h2, 16'h07FF, 8'hC3);
        bus_op(2'h2, 16'h0000, 8'h3C);
        bus_op(2'h1, 16'h07FF, 8'h00);
        check(rdata === 8'hC3, "ram top");
        bus_op(2'h1, 16'h0800, 8'h00);
        check(rdata === 8'h00, "ram alias");
        prog_in = 8'h96;
        bus_op(2'h0, 16'h0000, 8'h00);
        check(rdata === 8'h96, "fetch data");
        bus_op(2'h1, 16'h0000, 8'h00);
        check(rdata === 8'h3C, "data space");
        $display("test reads done");
    endtask

    task automatic wait_rst(input logic lvl, output int n);
        n = 0;
        while (cpu_rst !== lvl && n < 300) begin
            @(negedge clk_in);
            n++;
        end
    endtask

    task automatic quiet(output int n);
        n = 0;
        repeat (300) begin
            @(negedge clk_in);
            n = n + int'(cpu_rst !== 1'b0);
        end
    endtask

    task automatic t_watchdog();
        int n;
        int hi;
        kick_on = 1'b0;
        wait_rst(1'b1, n);
        check(n < 300, "no timeout");
        wait_rst(1'b0, hi);
        wait_rst(1'b1, n);
        check(hi >= HALF - 3 && hi <= HALF + 3, "reset width");
        check(n >= HALF - 3 && n <= HALF + 3, "run width");
        kick_on = 1'b1;
        wait_rst(1'b0, n);
        quiet(n);
        check(n == 0, "kicked reset");
        kick_on = 1'b0;
        jumper = 1'b1;
        quiet(n);
        check(n == 0, "disabled reset");
        manual = 1'b1;
        wait_rst(1'b1, n);
        check(n < 6, "manual reset");
        manual = 1'b0;
        wait_rst(1'b0, hi);
        check(hi >= HALF && hi < 300, "manual hold");
        // jumper fitted for the disabled and manual reset checks, never left fitted
        jumper = 1'b0;
        kick_on = 1'b1;
        $display("test watchdog done");
    endtask

    initial begin
        #(20_000 * 8);
        n_errors++;
        $display("MISMATCH at %0t: run hung", $time);
        end_of_test();
    end

    initial begin
        n_errors = 0;
        checks_done = 0;
        arst_n_in = 1'b0;
        req = 1'b0;
        kind = 2'h0;
        addr = 16'h0000;
        wdata = 8'h00;
        kick_on = 1'b1;
        manual = 1'b0;
        jumper = 1'b0;
        periph_in = 8'h00;
        prog_in = 8'h00;
        repeat (12) @(negedge clk_in);
        arst_n_in = 1'b1;
        check(latch === 32'h0000_0000, "latch reset");
        t_latches();
        t_reads();
        t_watchdog();
        end_of_test();
    end
endmodule // testbench
